/* common/usc_defines.svh */
// Constants of the serial status and interrupt-control block: offsets, field positions, reset values, timing.
// Assumes a 40 MHz system clock and a byte-wide register port with a 3-bit address.
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH
`define USC_ADDR_W 3
`define USC_OFS_ICTRL 3'h0
`define USC_OFS_TXHOLD 3'h1
`define USC_OFS_RXHOLD 3'h2
`define USC_OFS_STATUS 3'h3
`define USC_ICTRL_RESET 8'h01
`define USC_CTL_TXE 0
`define USC_CTL_RXF 1
`define USC_CTL_CTSCHG 2
`define USC_CTL_CTSLVL 3
`define USC_CTL_EN_LSB 4
`define USC_ST_ERR 0
`define USC_ST_FRAME 1
`define USC_ST_OVR 2
`define USC_ST_XMIP 3
`define USC_CLK_NS 25
`define USC_BIT_NS 8680
`define USC_BIT_CYC ((`USC_BIT_NS) / (`USC_CLK_NS))
`define USC_FRAME_LAST 4'h9
`define USC_DATA_LAST 3'h7
`endif

/* common/usc_pkg.sv */
// Types of the serial status and interrupt-control block: state enums and the state structs of each module.
// Assumes nothing beyond the defines header for widths.
package usc_pkg;
	typedef enum logic {TX_IDLE, TX_SHIFT} usc_tx_state_type;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usc_rx_state_type;
	typedef struct packed {
		usc_tx_state_type st;
		logic [9:0] shift;
		logic [3:0] bitIdx;
		logic [15:0] cyc;
		logic line;
	} usc_tx_type;
	typedef struct packed {
		usc_rx_state_type st;
		logic [7:0] data;
		logic [2:0] bitIdx;
		logic [15:0] cyc;
		logic done;
		logic frameErr;
	} usc_rx_type;
	typedef struct packed {
		logic [7:0] rdata;
		logic [3:0] irqEn;
		logic txEmpty;
		logic rxFull;
		logic ctsChange;
		logic ctsPrev;
		logic errSum;
		logic frameErr;
		logic overrun;
		logic [7:0] txHold;
		logic [7:0] rxHold;
		logic txLoad;
	} usc_core_type;
endpackage

/* common/usc_shift_if.sv */
// Link between the control core and its transmit and receive shifters.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
`default_nettype none
interface usc_shift_if;
	logic txLoad;
	logic [7:0] txData;
	logic txBusy;
	logic rxDone;
	logic [7:0] rxData;
	logic rxFrameErr;
	modport ctl(output txLoad, output txData, input txBusy, input rxDone, input rxData, input rxFrameErr);
	modport txs(input txLoad, input txData, output txBusy);
	modport rxs(output rxDone, output rxData, output rxFrameErr);
endinterface
`default_nettype wire

/* hdl/usc_rx_shift.sv */
// Receive shifter: finds a start bit, samples each bit at its centre, checks the stop bit.
// Assumes rxd is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "usc_defines.svh"
module usc_rx_shift (
	// Clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Serial line
	input wire logic rxd,
	// Core link
	usc_shift_if.rxs link
);
	usc_pkg::usc_rx_type s_q;
	usc_pkg::usc_rx_type s_d;

	// Bit timing and sampling; done is a one-cycle pulse
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.cyc = s_q.cyc + 16'h0001;
		unique case (s_q.st)
			usc_pkg::RX_IDLE:
			begin
				s_d.cyc = 16'h0000;
				if (!rxd)
					s_d.st = usc_pkg::RX_START;
			end
			usc_pkg::RX_START:
				if (s_q.cyc == 16'(`USC_BIT_CYC / 2 - 1))
				begin
					s_d.cyc = 16'h0000;
					s_d.bitIdx = 3'h0;
					s_d.st = rxd ? usc_pkg::RX_IDLE : usc_pkg::RX_DATA; // Glitch rejected
				end
			usc_pkg::RX_DATA:
				if (s_q.cyc == 16'(`USC_BIT_CYC - 1))
				begin
					s_d.cyc = 16'h0000;
					s_d.data = {rxd, s_q.data[7:1]};
					s_d.bitIdx = s_q.bitIdx + 3'h1;
					if (s_q.bitIdx == `USC_DATA_LAST)
						s_d.st = usc_pkg::RX_STOP;
				end
			usc_pkg::RX_STOP:
				if (s_q.cyc == 16'(`USC_BIT_CYC - 1))
				begin
					s_d.done = 1'b1;
					s_d.frameErr = ~rxd;
					s_d.st = usc_pkg::RX_IDLE;
				end
		endcase
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_q <= '{st: usc_pkg::RX_IDLE, data: 8'h00, bitIdx: 3'h0, cyc: 16'h0000, done: 1'b0, frameErr: 1'b0};
		else if (ce)
			s_q <= s_d;
	end

	assign link.rxDone = s_q.done;
	assign link.rxData = s_q.data;
	assign link.rxFrameErr = s_q.frameErr;
endmodule
`default_nettype wire

/* hdl/usc_top.sv */
// Serial port status and interrupt control: interrupt control register, holding registers,
// clear-to-send sampling, receive error summary and one level interrupt request.
// Assumes a byte-wide register port on clk, with read data valid only in the cycle after a read.
//
// Function
// [R1] Transmit-in-progress is high while a frame shifts out, low after its stop bit.
// [R2] Reset loads the interrupt control register with 01h: only transmit-empty set.
// [R3] Control register bits 3..0 are read-only flags, bits 7..4 writable enables.
// [R4] Transmit-empty sets when the holding byte moves into the shift register.
// [R5] A software write to the transmit holding register clears transmit-empty.
// [R6] Receive-full sets when a received frame lands in the receive holding register.
// [R7] A software read of the receive holding register clears receive-full.
// [R8] Clear-to-send change flag sets on any input change; control register read clears it.
// [R9] Clear-to-send level bit reads one while the active-low input is low.
// [R10] Flow-control enable gates an interrupt from the clear-to-send change flag.
// [R11] Transmit enable gates an interrupt from transmit-empty.
// [R12] Receive enable gates an interrupt from receive-full.
// [R13] Receive-error enable gates an interrupt from the receive-error summary bit.
// [R14] One interrupt output stays high while any enabled condition is pending.
`timescale 1ns/1ps
`default_nettype none
`include "usc_defines.svh"
module usc_top (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic [`USC_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Serial pins
	output logic txd,
	input wire logic rxd,
	input wire logic ctsN,
	// Status
	output logic txInProgress,
	output logic irq
);
	usc_pkg::usc_core_type s_q;
	usc_pkg::usc_core_type s_d;
	usc_shift_if link();

	logic wrTxHold;
	logic rdCtl;
	logic rdRxHold;
	logic rdStatus;
	logic txMove;
	logic ctsLevel;
	logic [7:0] ctlValue;
	logic [7:0] statusValue;
	logic [3:0] irqSource;
	logic [3:0] irqPending;

	// Transmit shifter
	usc_tx_shift txShift (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.link(link.txs),
		.txd(txd)
	);

	// Receive shifter
	usc_rx_shift rxShift (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.rxd(rxd),
		.link(link.rxs)
	);

	// Register strobes decoded from the plain port
	assign wrTxHold = regWr && (regAddr == `USC_OFS_TXHOLD);
	assign rdCtl = regRd && (regAddr == `USC_OFS_ICTRL);
	assign rdRxHold = regRd && (regAddr == `USC_OFS_RXHOLD);
	assign rdStatus = regRd && (regAddr == `USC_OFS_STATUS);

	// A byte moves only when the shifter is idle and no load is already in flight
	assign txMove = !s_q.txEmpty && !link.txBusy && !s_q.txLoad;

	// Level bit reflects the active-low pin inverted
	assign ctsLevel = ~s_q.ctsPrev; // [R9]

	// Load is held one cycle so the shifter sees a registered strobe
	assign link.txLoad = s_q.txLoad;
	assign link.txData = s_q.txHold;

	// Busy also covers the cycle in which the load travels to the shifter
	assign txInProgress = link.txBusy || s_q.txLoad; // [R1]

	// Control register image: flags low, enables high
	always_comb
	begin
		ctlValue = 8'h00;
		ctlValue[`USC_CTL_TXE] = s_q.txEmpty; // [R3]
		ctlValue[`USC_CTL_RXF] = s_q.rxFull;
		ctlValue[`USC_CTL_CTSCHG] = s_q.ctsChange;
		ctlValue[`USC_CTL_CTSLVL] = ctsLevel;
		ctlValue[7:`USC_CTL_EN_LSB] = s_q.irqEn;
	end

	// Status register image; upper bits read as zero
	always_comb
	begin
		statusValue = 8'h00;
		statusValue[`USC_ST_ERR] = s_q.errSum;
		statusValue[`USC_ST_FRAME] = s_q.frameErr;
		statusValue[`USC_ST_OVR] = s_q.overrun;
		statusValue[`USC_ST_XMIP] = txInProgress;
	end

	// Interrupt sources in enable-bit order: flow, transmit, receive, receive error
	assign irqSource[0] = s_q.ctsChange;
	assign irqSource[1] = s_q.txEmpty;
	assign irqSource[2] = s_q.rxFull;
	assign irqSource[3] = s_q.errSum;

	// Each source gated by its own enable
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : gateIrq
			assign irqPending[gi] = irqSource[gi] && s_q.irqEn[gi]; // [R10] [R11] [R12] [R13]
		end
	endgenerate

	// Level request, so a flag left pending keeps the line up until software services it
	assign irq = |irqPending; // [R14]

	// Core next-state logic
	always_comb
	begin
		s_d = s_q;
		s_d.txLoad = 1'b0;
		s_d.rdata = 8'h00;

		// Read data path; unmapped addresses answer zero
		if (regRd)
		begin
			unique case (regAddr)
				`USC_OFS_ICTRL: s_d.rdata = ctlValue;
				`USC_OFS_TXHOLD: s_d.rdata = s_q.txHold;
				`USC_OFS_RXHOLD: s_d.rdata = s_q.rxHold;
				`USC_OFS_STATUS: s_d.rdata = statusValue;
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Only the enable field of the control register is writable
		if (regWr && (regAddr == `USC_OFS_ICTRL))
			s_d.irqEn = regWdata[7:`USC_CTL_EN_LSB]; // [R3]

		// Transmit side: move the held byte, then a later write reloads it
		if (txMove)
		begin
			s_d.txLoad = 1'b1;
			s_d.txEmpty = 1'b1; // [R4]
		end
		// A write in the move cycle lands just as the shifter takes the holding register,
		// so that byte is the one sent and empty stays set; otherwise it would go out twice
		if (wrTxHold)
		begin
			s_d.txHold = regWdata;
			s_d.txEmpty = txMove; // [R5]
		end

		// Receive side: reading the holding register clears full
		if (rdRxHold)
			s_d.rxFull = 1'b0; // [R7]
		// Reading the status register clears the error bits
		if (rdStatus)
		begin
			s_d.errSum = 1'b0;
			s_d.frameErr = 1'b0;
			s_d.overrun = 1'b0;
		end
		// A frame landing in the same cycle as a clearing read wins
		if (link.rxDone)
		begin
			s_d.rxHold = link.rxData;
			s_d.rxFull = 1'b1; // [R6]
			if (s_q.rxFull && !rdRxHold)
			begin
				s_d.overrun = 1'b1;
				s_d.errSum = 1'b1;
			end
			if (link.rxFrameErr)
			begin
				s_d.frameErr = 1'b1;
				s_d.errSum = 1'b1;
			end
		end

		// Clear-to-send tracking; a change seen during a clearing read is kept
		s_d.ctsPrev = ctsN;
		if (rdCtl)
			s_d.ctsChange = 1'b0; // [R8]
		if (ctsN != s_q.ctsPrev)
			s_d.ctsChange = 1'b1; // [R8]
	end

	// State register; clock enable freezes everything, reset does not wait for it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.irqEn <= 4'(`USC_ICTRL_RESET >> `USC_CTL_EN_LSB); // [R2]
			s_q.txEmpty <= 1'(`USC_ICTRL_RESET >> `USC_CTL_TXE); // [R2]
			s_q.ctsPrev <= 1'b1;
		end
		else if (ce)
			s_q <= s_d;
	end

	// Read data comes straight from its register
	assign regRdata = s_q.rdata;
endmodule
`default_nettype wire

/* hdl/usc_tx_shift.sv */
// Transmit shifter: one start bit, eight data bits LSB first, one stop bit.
// Assumes a load only arrives while idle; a load during a frame is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "usc_defines.svh"
module usc_tx_shift (
	// Clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Core link
	usc_shift_if.txs link,
	// Serial line
	output logic txd
);
	usc_pkg::usc_tx_type s_q;
	usc_pkg::usc_tx_type s_d;

	// Frame sequencing; busy covers the full stop bit
	always_comb
	begin
		s_d = s_q;
		if (s_q.st == usc_pkg::TX_IDLE)
		begin
			if (link.txLoad)
			begin
				s_d.shift = {1'b1, link.txData, 1'b0};
				s_d.bitIdx = 4'h0;
				s_d.cyc = 16'h0000;
				s_d.line = 1'b0;
				s_d.st = usc_pkg::TX_SHIFT;
			end
		end
		else if (s_q.cyc == 16'(`USC_BIT_CYC - 1))
		begin
			s_d.cyc = 16'h0000;
			if (s_q.bitIdx == `USC_FRAME_LAST)
			begin
				s_d.line = 1'b1;
				s_d.st = usc_pkg::TX_IDLE;
			end
			else
			begin
				s_d.bitIdx = s_q.bitIdx + 4'h1;
				s_d.shift = {1'b1, s_q.shift[9:1]};
				s_d.line = s_q.shift[1];
			end
		end
		else
			s_d.cyc = s_q.cyc + 16'h0001;
	end

	// State register; line idles high
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_q <= '{st: usc_pkg::TX_IDLE, shift: 10'h3FF, bitIdx: 4'h0, cyc: 16'h0000, line: 1'b1};
		else if (ce)
			s_q <= s_d;
	end

	assign link.txBusy = (s_q.st == usc_pkg::TX_SHIFT);
	assign txd = s_q.line;
endmodule
`default_nettype wire

/* verification/test_usc_top.sv */
// Self-checking bench of usc_top with a remote serial device on its pins.
// Assumes the checker binds itself to usc_top.
`timescale 1ns/1ps
`default_nettype none
`include "usc_defines.svh"
module test_usc_top;
	logic clk, rst_n, ce, regWr, regRd, txd, rxd, ctsN, txInProgress, irq;
	logic [`USC_ADDR_W-1:0] regAddr;
	logic [7:0] regWdata, regRdata, rv, a, b;
	int failures = 0;
	int checkCount = 0;
	usc_top u_usc_top (.clk, .rst_n, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.txd, .rxd, .ctsN, .txInProgress, .irq);
	usc_remote_dev u_usc_remote_dev (.clk, .txd, .rxd, .ctsN);
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] seen, exp);
		checkCount++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One-cycle strobes; the #1 lets the taking edge settle before checks
	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= ad;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] ad);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= ad;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		rv = regRdata;
	endtask
	task automatic tRegs;
		rd(`USC_OFS_ICTRL);
		chk("ctl reset", rv, `USC_ICTRL_RESET);
		// A write taken while ce is low must leave the enables alone
		@(posedge clk);
		ce <= 1'b0;
		wr(`USC_OFS_ICTRL, 8'hF0);
		@(posedge clk);
		ce <= 1'b1;
		rd(`USC_OFS_ICTRL);
		chk("ctl frozen", rv, `USC_ICTRL_RESET);
		wr(`USC_OFS_ICTRL, 8'hFF);
		chk("irq tx", irq, 8'h01);
		rd(`USC_OFS_ICTRL);
		chk("ctl ro", rv, 8'hF1);
		wr(`USC_OFS_ICTRL, 8'h00);
		chk("irq off", irq, 8'h00);
		rd(3'h7);
		chk("unmapped", rv, 8'h00);
	endtask
	// Second byte written while the first shifts out
	task automatic tTx;
		wr(`USC_OFS_ICTRL, 8'h20);
		fork
			begin
				u_usc_remote_dev.getFrame(a);
				u_usc_remote_dev.getFrame(b);
			end
			begin
				wr(`USC_OFS_TXHOLD, 8'hA5);
				// Busy rises with the load strobe, one edge after the write
				@(posedge clk);
				#1;
				chk("busy", txInProgress, 8'h01);
				repeat (4) @(posedge clk);
				rd(`USC_OFS_ICTRL);
				chk("empty", rv[0], 8'h01);
				wr(`USC_OFS_TXHOLD, 8'h3C);
				chk("irq held", irq, 8'h00);
				rd(`USC_OFS_ICTRL);
				chk("loaded", rv[0], 8'h00);
			end
		join
		repeat (200) @(posedge clk);
		#1;
		chk("done", txInProgress, 8'h00);
		chk("byte a", a, 8'hA5);
		chk("byte b", b, 8'h3C);
		chk("irq tx", irq, 8'h01);
	endtask
	task automatic tRx;
		wr(`USC_OFS_ICTRL, 8'h40);
		u_usc_remote_dev.sendFrame(8'h5A, 1'b1);
		repeat (4) @(posedge clk);
		#1;
		chk("irq rx", irq, 8'h01);
		rd(`USC_OFS_ICTRL);
		chk("full", rv[1], 8'h01);
		rd(`USC_OFS_RXHOLD);
		chk("rx data", rv, 8'h5A);
		chk("irq rx off", irq, 8'h00);
		rd(`USC_OFS_ICTRL);
		chk("cleared", rv[1], 8'h00);
	endtask
	task automatic tErr;
		wr(`USC_OFS_ICTRL, 8'h80);
		u_usc_remote_dev.sendFrame(8'h0F, 1'b0);
		repeat (4) @(posedge clk);
		#1;
		chk("irq err", irq, 8'h01);
		rd(`USC_OFS_STATUS);
		chk("err sum", rv[0], 8'h01);
		chk("frame err", rv[1], 8'h01);
		chk("irq err off", irq, 8'h00);
		rd(`USC_OFS_RXHOLD);
	endtask
	// Change with the flow interrupt on, then off
	task automatic tCts;
		wr(`USC_OFS_ICTRL, 8'h10);
		rd(`USC_OFS_ICTRL);
		u_usc_remote_dev.setCts(1'b0);
		repeat (3) @(posedge clk);
		#1;
		chk("irq flow", irq, 8'h01);
		rd(`USC_OFS_ICTRL);
		chk("cts low", rv, 8'h1D);
		chk("irq flow off", irq, 8'h00);
		rd(`USC_OFS_ICTRL);
		chk("change read", rv, 8'h19);
		wr(`USC_OFS_ICTRL, 8'h00);
		u_usc_remote_dev.setCts(1'b1);
		repeat (4) @(posedge clk);
		#1;
		chk("irq masked", irq, 8'h00);
		rd(`USC_OFS_ICTRL);
		chk("cts high", rv, 8'h05);
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Reset for ten cycles, then the scenarios
	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 3'h0;
		regWdata = 8'h00;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		tRegs;
		tTx;
		tRx;
		tErr;
		tCts;
		test_done;
	end
	// The run needs about 15000 cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		test_done;
	end
endmodule
`default_nettype wire

/* verification/usc_remote_dev.sv */
// Remote serial device: drives rxd and ctsN, listens on txd, 8N1 LSB first.
// Assumes the bench calls each task from one process at a time.
`timescale 1ns/1ps
`default_nettype none
`include "usc_defines.svh"
module usc_remote_dev (
	// Clock
	input wire logic clk,
	// Serial pins
	input wire logic txd,
	output var logic rxd,
	output var logic ctsN
);
	localparam int Bit = `USC_BIT_CYC;
	// Lines idle high
	initial
	begin
		rxd = 1'b1;
		ctsN = 1'b1;
	end
	// A broken stop bit is cut short so the idle low cannot pass for a new start
	task automatic sendFrame(input logic [7:0] d, input logic stopBit);
		logic [9:0] f;
		f = {stopBit, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			rxd <= f[i];
			repeat ((i == 9 && !stopBit) ? Bit / 2 + 20 : Bit - 1) @(posedge clk);
		end
		@(posedge clk);
		rxd <= 1'b1;
	endtask
	// Wait for a start bit, sample each data bit at its centre
	task automatic getFrame(output logic [7:0] d);
		int n = 0;
		while (txd === 1'b1 && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		repeat (Bit + Bit / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			d[i] = txd;
			repeat (Bit) @(posedge clk);
		end
	endtask
	// Change clear-to-send just after an edge
	task automatic setCts(input logic v);
		@(posedge clk);
		ctsN <= v;
	endtask
endmodule
`default_nettype wire

/* verification/usc_top_chk.sv */
// Checker of the serial status block, bound to usc_top.
// Assumes one clock; strobes count only at edges where ce is high.
`timescale 1ns/1ps
`default_nettype none
`include "usc_defines.svh"
module usc_top_chk (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic [`USC_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	// Pins and status
	input wire logic txd,
	input wire logic rxd,
	input wire logic ctsN,
	input wire logic txInProgress,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic ctlRd;
	// Control register read taken at this edge
	assign ctlRd = regRd && regAddr == `USC_OFS_ICTRL && ce;
	// Read data stands one cycle only; a frozen edge keeps the old value
	rdata_idle_a: assert property ($past(ce) && !$past(regRd) |-> regRdata == 8'h00)
		else $error("read data not idle");
	// Write edge, then the load cycle, then the start bit on the line
	tx_start_a: assert property (regWr && regAddr == `USC_OFS_TXHOLD && ce && !txInProgress
		|=> ##1 txInProgress ##1 !txd) else $error("frame did not start");
	txd_idle_a: assert property (!txInProgress |-> txd)
		else $error("line not idle");
	irq_reset_a: assert property (!$past(rst_n) |-> !irq)
		else $error("irq after reset");
	cts_change_a: assert property ($changed(ctsN) ##1 !regRd [*3] ##1 ctlRd
		|=> regRdata[`USC_CTL_CTSCHG]) else $error("change flag missing");
	cts_level_a: assert property ($stable(ctsN) [*3] ##0 ctlRd
		|=> regRdata[`USC_CTL_CTSLVL] == !$past(ctsN)) else $error("level bit wrong");
	irq_mask_a: assert property (regWr && regAddr == `USC_OFS_ICTRL && regWdata[7:4] == 4'h0 && ce
		|=> !irq) else $error("irq with enables off");
	irq_pend_a: assert property ($past(ctlRd) && |(regRdata[6:5] & regRdata[1:0]) |-> irq)
		else $error("pending irq missing");
endmodule
bind usc_top usc_top_chk u_usc_top_chk (.clk, .rst_n, .ce, .regAddr, .regWdata, .regWr, .regRd,
	.regRdata, .txd, .rxd, .ctsN, .txInProgress, .irq);
`default_nettype wire
